// ---- design/hs_cfg.svh ----
`ifndef HS_CFG_SVH
`define HS_CFG_SVH
`define CLK_MHZ 200
`define OWN_ADDR 7'h10
`define C_OPER 8'h01
`define C_CLR 8'h03
`define C_CAP 8'h19
`define C_SBYTE 8'h78
`define C_SWORD 8'h79
`define C_SVOUT 8'h7a
`define C_SIOUT 8'h7b
`define C_SIN 8'h7c
`define C_STEMP 8'h7d
`define C_SMFR 8'h80
`define C_PREV 8'h98
`define C_MID 8'h99
`define C_MMOD 8'h9a
`define C_MREV 8'h9b
`define C_PCYC 8'hd9
`define C_CONV 8'hf3
`define ON_BIT 7
`define OPER_RST 8'h80
`define PIN_RST 7'h01
`define CAP_VAL 8'hb0
`define PREV_VAL 8'h22
`define NO_DATA 8'hff
`define PCYC_S 5
`define TMO_MS 25
`define F_OC 0
`define F_OV 1
`define F_UV 2
`define F_OT 3
`define F_FET 4
`define W_IOC 5
`define W_VOV 6
`define W_VUV 7
`define W_OP 8
`define W_OT 9
`define W_OOV 10
`define W_OUV 11
`define N_LAT 12
`define N_WARN 7
`endif

// ---- design/hs_cmd.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hs_cfg.svh"
module hs_cmd #(
    parameter logic [6:0]  ADDR        = `OWN_ADDR,
    parameter int unsigned PCYC_CYCLES = `PCYC_S * `CLK_MHZ * 1000000,
    parameter int unsigned TMO_CYCLES  = `TMO_MS * `CLK_MHZ * 1000,
    // identity strings, arbitrary values
    parameter logic [31:0] ID_STR  = "XYZC",
    parameter logic [31:0] MOD_STR = "HSC1",
    parameter logic [31:0] REV_STR = "A0"
)(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               scl_in,
    input  wire logic               sda_in,
    output logic                    sda_out,
    output logic                    sda_oe,
    input  wire logic               undervoltage_input,
    input  wire logic               overvoltage_input,
    input  wire logic               power_good_sense_input,
    input  wire logic               hs_permit,
    input  wire logic               oc_timeout_input,
    input  wire logic               overtemp_input,
    input  wire logic               fet_health_input,
    input  wire logic [`N_WARN-1:0] warn_in,
    input  wire logic               alert1_warn_en,
    input  wire logic               alert2_fault_en,
    input  wire logic               alert2_warn_en,
    output logic                    gate_drive,
    output logic                    power_good_output,
    output logic                    fault_n,
    output logic                    alert1,
    output logic                    second_alert_capable_pin,
    output logic                    conv_start,
    output logic                    output_enabled,
    output logic                    power_cycling
);
    import hs_pkg::*;
    localparam int PW = $clog2(PCYC_CYCLES + 1);
    logic [6:0]         pin_s1;
    logic [6:0]         pin_s2;
    logic               uv_ok;
    logic               ov_hi;
    logic               pgs;
    logic               permit;
    logic               seg_stop;
    logic               bus_err;
    logic               addr_hit;
    logic               addr_rd;
    logic               wr_valid;
    byte_t              wr_byte;
    logic               rd_req;
    byte_t              rd_data;
    byte_t              cmd;
    logic [3:0]         idx;
    logic [3:0]         ridx;
    logic               seg_wr;
    logic               p_op_v;
    byte_t              p_op;
    logic               p_clr;
    logic               p_pcyc;
    logic               p_conv;
    byte_t              op_reg;
    logic               on_bit;
    logic               clr_lat;
    logic [`N_LAT-1:0]  sets;
    logic [`N_LAT-1:0]  lat;
    logic               fault_any;
    logic               warn_any;
    logic [PW-1:0]      pc_cnt;
    byte_t              s_in;
    byte_t              s_iout;
    byte_t              s_temp;
    byte_t              s_vout;
    byte_t              s_mfr;
    byte_t              s_byte;
    byte_t              s_hi;
    byte_t              rd_val;

    // block read: count first, then string bytes high to low
    function automatic byte_t str_byte(input logic [31:0] s,
                                       input logic [3:0] len,
                                       input logic [3:0] i);
        byte_t b;
        b = `NO_DATA;
        if (i == 4'h0)
            b = {4'h0, len};
        else if (i <= len)
            b = s[8*(len-i) +: 8];
        return b;
    endfunction : str_byte

    // --------------------------------
    // pin synchronisers
    // --------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1 <= `PIN_RST; // idle as supply ok, no false uv latch
            pin_s2 <= `PIN_RST;
        end
        else
        begin
            pin_s1 <= {fet_health_input, overtemp_input, oc_timeout_input,
                       hs_permit, power_good_sense_input,
                       overvoltage_input, undervoltage_input};
            pin_s2 <= pin_s1;
        end
    end
    assign uv_ok  = pin_s2[0];
    assign ov_hi  = pin_s2[1];
    assign pgs    = pin_s2[2];
    assign permit = pin_s2[3];

    // --------------------------------
    // bus target
    // --------------------------------
    hs_i2c_target #(
        .ADDR (ADDR),
        .TMO  (TMO_CYCLES)
    ) u_tgt (
        .clock    (clock),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe   (sda_oe),
        .seg_stop (seg_stop),
        .bus_err  (bus_err),
        .addr_hit (addr_hit),
        .addr_rd  (addr_rd),
        .wr_valid (wr_valid),
        .wr_byte  (wr_byte),
        .rd_req   (rd_req),
        .rd_byte  (rd_data)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            sda_out <= 1'b0;
        else
            sda_out <= 1'b0;
    end

    // --------------------------------
    // command capture and pending set
    // --------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd    <= '0;
            idx    <= '0;
            seg_wr <= 1'b0;
            p_op_v <= 1'b0;
            p_op   <= '0;
            p_clr  <= 1'b0;
            p_pcyc <= 1'b0;
            p_conv <= 1'b0;
        end
        else if (seg_stop || bus_err)
        begin
            // stop commits, timeout drops; both empty the pending set
            p_op_v <= 1'b0;
            p_clr  <= 1'b0;
            p_pcyc <= 1'b0;
            p_conv <= 1'b0;
            seg_wr <= 1'b0;
        end
        else if (addr_hit)
        begin
            idx    <= addr_rd ? 4'h1 : 4'h0;
            seg_wr <= ~addr_rd;
        end
        else if (rd_req)
            idx <= (idx == 4'hf) ? idx : idx + 1'b1;
        else if (wr_valid && seg_wr)
        begin
            // write data is only held here, acted on at stop
            idx <= (idx == 4'hf) ? idx : idx + 1'b1;
            if (idx == 4'h0)
            begin
                cmd <= wr_byte;
                if (wr_byte == `C_CLR)
                    p_clr <= 1'b1;
                else if (wr_byte == `C_PCYC)
                    p_pcyc <= 1'b1;
                else if (wr_byte == `C_CONV)
                    p_conv <= 1'b1;
            end
            else if (idx == 4'h1 && cmd == `C_OPER)
            begin
                p_op_v <= 1'b1;
                p_op   <= wr_byte;
            end
        end
    end

    // --------------------------------
    // commit at stop, all in one edge
    // --------------------------------
    assign clr_lat = seg_stop & (p_clr | (p_op_v & p_op[`ON_BIT] & ~on_bit));
    assign on_bit  = op_reg[`ON_BIT];

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            op_reg <= `OPER_RST;
        else if (seg_stop && p_op_v)
            op_reg <= p_op;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            conv_start <= 1'b0;
        else
            conv_start <= seg_stop & p_conv;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_cnt        <= '0;
            power_cycling <= 1'b0;
        end
        else if (seg_stop && p_pcyc)
        begin
            pc_cnt        <= PW'(PCYC_CYCLES - 1);
            power_cycling <= 1'b1;
        end
        else if (power_cycling)
        begin
            pc_cnt <= pc_cnt - 1'b1;
            if (pc_cnt == '0)
                power_cycling <= 1'b0;
        end
    end

    // --------------------------------
    // latched status
    // --------------------------------
    assign sets = {warn_in, pin_s2[6], pin_s2[5], ~uv_ok, ov_hi, pin_s2[4]};
    hs_latch #(
        .N (`N_LAT)
    ) u_lat (
        .clock (clock),
        .rst_n (rst_n),
        .set   (sets),
        .clr   (clr_lat),
        .q     (lat)
    );
    assign fault_any = |lat[`F_FET:`F_OC];
    assign warn_any  = |lat[`W_OUV:`W_IOC];

    // --------------------------------
    // gate, power good and pins
    // --------------------------------
    // warnings are kept out of the gate term on purpose
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gate_drive        <= 1'b0;
            power_good_output <= 1'b0;
            fault_n           <= 1'b1;
            output_enabled    <= 1'b0;
        end
        else
        begin
            gate_drive <= on_bit & uv_ok & ~ov_hi & permit & ~power_cycling
                          & ~lat[`F_OC] & ~lat[`F_OT] & ~lat[`F_FET];
            power_good_output <= gate_drive & pgs & ~fault_any;
            fault_n           <= ~fault_any;
            output_enabled    <= gate_drive;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            alert1                   <= 1'b0;
            second_alert_capable_pin <= 1'b0;
        end
        else
        begin
            alert1 <= alert1_warn_en & warn_any;
            second_alert_capable_pin <= (alert2_fault_en & fault_any)
                                        | (alert2_warn_en & warn_any);
        end
    end

    // --------------------------------
    // status registers
    // --------------------------------
    assign s_in   = {lat[`F_OV], lat[`W_VOV], lat[`W_VUV], lat[`F_UV],
                     3'h0, lat[`W_OP]};
    assign s_iout = {lat[`F_OC], 1'b0, lat[`W_IOC], 5'h00};
    assign s_temp = {lat[`F_OT], lat[`W_OT], 6'h00};
    assign s_vout = {1'b0, lat[`W_OOV], lat[`W_OUV], 5'h00};
    assign s_mfr  = {7'h00, lat[`F_FET]};
    assign s_byte = {1'b0, ~output_enabled, 1'b0, lat[`F_OC], lat[`F_UV],
                     lat[`F_OT] | lat[`W_OT], 1'b0,
                     lat[`F_OV] | lat[`W_VOV] | lat[`W_VUV] | lat[`W_OP]
                     | lat[`W_IOC] | (|s_vout) | lat[`F_FET]};
    assign s_hi   = {|s_vout, |s_iout, |s_in, |s_mfr, ~power_good_output,
                     2'h0, lat[`F_FET]};

    // --------------------------------
    // read data
    // --------------------------------
    // reads never touch the pending set, so a group stays write only
    assign ridx = addr_hit ? 4'h0 : idx;
    always_comb
    begin
        rd_val = `NO_DATA;
        if (cmd == `C_SBYTE)
            rd_val = s_byte;
        else if (cmd == `C_SWORD)
            rd_val = (ridx == 4'h0) ? s_byte : s_hi;
        else if (cmd == `C_SIN)
            rd_val = s_in;
        else if (cmd == `C_SIOUT)
            rd_val = s_iout;
        else if (cmd == `C_STEMP)
            rd_val = s_temp;
        else if (cmd == `C_SVOUT)
            rd_val = s_vout;
        else if (cmd == `C_SMFR)
            rd_val = s_mfr;
        else if (cmd == `C_OPER)
            rd_val = op_reg;
        else if (cmd == `C_CAP)
            rd_val = `CAP_VAL;
        else if (cmd == `C_PREV)
            rd_val = `PREV_VAL;
        else if (cmd == `C_MID)
            rd_val = str_byte(ID_STR, 4'h4, ridx);
        else if (cmd == `C_MMOD)
            rd_val = str_byte(MOD_STR, 4'h4, ridx);
        else if (cmd == `C_MREV)
            rd_val = str_byte(REV_STR, 4'h2, ridx);
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            rd_data <= `NO_DATA;
        else if ((addr_hit && addr_rd) || rd_req)
            rd_data <= rd_val;
    end
endmodule : hs_cmd
`default_nettype wire

// ---- design/hs_i2c_target.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "hs_cfg.svh"
module hs_i2c_target #(
    parameter logic [6:0]  ADDR = `OWN_ADDR,
    parameter int unsigned TMO  = `TMO_MS * `CLK_MHZ * 1000
)(
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          scl_in,
    input  wire logic          sda_in,
    output logic               sda_oe,
    output logic               seg_stop,
    output logic               bus_err,
    output logic               addr_hit,
    output logic               addr_rd,
    output logic               wr_valid,
    output hs_pkg::byte_t      wr_byte,
    output logic               rd_req,
    input  wire hs_pkg::byte_t rd_byte
);
    import hs_pkg::*;
    localparam int TW = $clog2(TMO + 1);
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    i2c_e          st;
    logic [3:0]    cnt;
    byte_t         sh;
    logic [TW-1:0] tmo;
    logic          rise;
    logic          fall;
    logic          start_c;
    logic          stop_c;
    logic          tmo_hit;
    logic          byte_end;
    // --------------------------------
    // pin sampling and bus conditions
    // --------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end
        else
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end
    assign rise     = scl_s[1] & ~scl_s[2];
    assign fall     = ~scl_s[1] & scl_s[2];
    assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    assign tmo_hit  = (tmo == TW'(TMO - 1));
    assign byte_end = fall & (cnt == 4'h8);
    // clock stuck low ends the transfer so pending data can be dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            tmo <= '0;
        else if (st == I_IDLE || scl_s[1] || tmo_hit)
            tmo <= '0;
        else
            tmo <= tmo + 1'b1;
    end
    // --------------------------------
    // byte engine
    // --------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st     <= I_IDLE;
            cnt    <= '0;
            sh     <= '0;
            sda_oe <= 1'b0;
        end
        else if (start_c)
        begin
            st     <= I_ADDR;
            cnt    <= '0;
            sda_oe <= 1'b0;
        end
        else if (stop_c || tmo_hit)
        begin
            st     <= I_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st)
                I_ADDR, I_WR:
                    if (rise)
                    begin
                        sh  <= {sh[6:0], sda_s[1]};
                        cnt <= cnt + 1'b1;
                    end
                    else if (byte_end)
                    begin
                        cnt <= '0;
                        if (st == I_WR)
                        begin
                            sda_oe <= 1'b1;
                            st     <= I_WACK;
                        end
                        else if (sh[7:1] == ADDR)
                        begin
                            sda_oe <= 1'b1;
                            st     <= I_AACK;
                        end
                        else
                            st <= I_IDLE;
                    end
                I_WACK:
                    if (fall)
                    begin
                        sda_oe <= 1'b0;
                        st     <= I_WR;
                    end
                I_AACK, I_RNXT:
                    if (fall)
                    begin
                        if (st == I_RNXT || sh[0])
                        begin
                            sda_oe <= ~rd_byte[7];
                            sh     <= {rd_byte[6:0], 1'b0};
                            cnt    <= 4'h1;
                            st     <= I_RD;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            st     <= I_WR;
                        end
                    end
                I_RD:
                    if (byte_end)
                    begin
                        sda_oe <= 1'b0;
                        st     <= I_RACK;
                    end
                    else if (fall)
                    begin
                        sda_oe <= ~sh[7];
                        sh     <= {sh[6:0], 1'b0};
                        cnt    <= cnt + 1'b1;
                    end
                I_RACK:
                    if (rise)
                        st <= sda_s[1] ? I_IDLE : I_RNXT;
                default:
                    st <= I_IDLE;
            endcase
        end
    end
    // --------------------------------
    // event pulses
    // --------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_stop <= 1'b0;
            bus_err  <= 1'b0;
            addr_hit <= 1'b0;
            addr_rd  <= 1'b0;
            wr_valid <= 1'b0;
            wr_byte  <= '0;
            rd_req   <= 1'b0;
        end
        else
        begin
            seg_stop <= stop_c;
            bus_err  <= tmo_hit;
            addr_hit <= (st == I_ADDR) & byte_end & (sh[7:1] == ADDR);
            if ((st == I_ADDR) & byte_end)
                addr_rd <= sh[0];
            wr_valid <= (st == I_WR) & byte_end & ~start_c & ~stop_c;
            if ((st == I_WR) & byte_end)
                wr_byte <= sh;
            rd_req <= (st == I_RACK) & rise & ~sda_s[1];
        end
    end
endmodule : hs_i2c_target
`default_nettype wire

// ---- design/hs_latch.sv ----
`timescale 1ns/100ps
`default_nettype none
module hs_latch #(
    parameter int N = 12
)(
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] set,
    input  wire logic         clr,
    output logic      [N-1:0] q
);
    // set beats clear so a live condition re-latches at once
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= (q & ~{N{clr}}) | set;
    end
endmodule : hs_latch
`default_nettype wire

// ---- design/hs_pkg.sv ----
package hs_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [7:0] {
        I_IDLE = 8'h01,
        I_ADDR = 8'h02,
        I_AACK = 8'h04,
        I_WR   = 8'h08,
        I_WACK = 8'h10,
        I_RD   = 8'h20,
        I_RACK = 8'h40,
        I_RNXT = 8'h80
    } i2c_e;
endpackage : hs_pkg

// ---- testbench/hs_cmd_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module hs_cmd_asserts (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       undervoltage_input,
    input wire logic       overvoltage_input,
    input wire logic       hs_permit,
    input wire logic       oc_timeout_input,
    input wire logic       fet_health_input,
    input wire logic       gate_drive,
    input wire logic       power_good_output,
    input wire logic       fault_n,
    input wire logic       conv_start,
    input wire logic       output_enabled,
    input wire logic       power_cycling
);
    // ----
    // gate and status relations
    // ----
    // repeat counts allow for the input synchronisers
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    AST_UV: assert property (!undervoltage_input [*5] |-> !gate_drive)
        else $error("gate on with low supply");
    AST_OV: assert property (overvoltage_input [*5] |-> !gate_drive)
        else $error("gate on with overvoltage");
    AST_PERMIT: assert property (!hs_permit [*5] |-> !gate_drive)
        else $error("gate on without permit");
    AST_OE: assert property (output_enabled == $past(gate_drive))
        else $error("enable flag wrong");
    AST_OC: assert property (oc_timeout_input [*6] |-> !fault_n && !gate_drive)
        else $error("overcurrent not acted on");
    AST_FET: assert property (fet_health_input [*6] |-> !power_good_output)
        else $error("power good kept on fault");
    AST_PCYC: assert property (power_cycling [*3] |-> !gate_drive)
        else $error("gate on in power cycle");
    AST_CONV: assert property (conv_start |=> !conv_start)
        else $error("conversion start too long");
    cover property (conv_start);
    cover property ($rose(power_cycling));
    cover property ($fell(fault_n));
endmodule : hs_cmd_asserts
bind hs_cmd hs_cmd_asserts chk_u (.clock(clock), .rst_n(rst_n),
    .undervoltage_input(undervoltage_input), .overvoltage_input(overvoltage_input),
    .hs_permit(hs_permit), .oc_timeout_input(oc_timeout_input),
    .fet_health_input(fet_health_input), .gate_drive(gate_drive),
    .power_good_output(power_good_output), .fault_n(fault_n), .conv_start(conv_start),
    .output_enabled(output_enabled), .power_cycling(power_cycling));
`default_nettype wire

// ---- testbench/i2c_host.sv ----
`timescale 1ns/100ps
`default_nettype none
module i2c_host (
    output logic       scl,
    output logic       sda_low,
    output logic [7:0] rd_data,
    output logic       rd_tick,
    input  wire logic  sda
);
    // ----
    // bus master, clock still between frames
    // ----
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_tick = 1'b0;
    end
    task automatic bit_io(input logic b, output logic r);
        #20 sda_low = ~b;
        #60 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask : bit_io
    // also repeated start between segments
    task automatic start();
        #20 sda_low = 1'b0;
        #60 scl = 1'b1;
        #80 sda_low = 1'b1;
        #80 scl = 1'b0;
    endtask : start
    // single stop after last segment
    task automatic stop();
        #20 sda_low = 1'b1;
        #60 scl = 1'b1;
        #80 sda_low = 1'b0;
        #80;
    endtask : stop
    task automatic wr(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : wr
    task automatic rd(input logic more, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(~more, r);
        rd_data = v;
        rd_tick = ~rd_tick;
    endtask : rd
endmodule : i2c_host
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import hs_pkg::*;
    logic       clock, rst_n, scl, sda_low, sda_out, sda_oe, uv, ov, perm, oc, fet;
    logic       gate, pg, fault_n, a1, a2, conv, oe, pcyc, tick, pgi, ot;
    logic [6:0] warn;
    byte_t      rdd, sb;
    wire logic  sda = ~(sda_low | sda_oe);
    int         miscompares, num_checks, convs;
    byte_t      expq[$];
    // ----
    // design and bus master
    // ----
    hs_cmd #(.PCYC_CYCLES(200), .TMO_CYCLES(2000)) dut_u (.clock(clock), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .undervoltage_input(uv), .overvoltage_input(ov), .power_good_sense_input(pgi),
        .hs_permit(perm), .oc_timeout_input(oc), .overtemp_input(ot),
        .fet_health_input(fet), .warn_in(warn), .alert1_warn_en(1'b1),
        .alert2_fault_en(1'b1), .alert2_warn_en(1'b0), .gate_drive(gate),
        .power_good_output(pg), .fault_n(fault_n), .alert1(a1),
        .second_alert_capable_pin(a2), .conv_start(conv), .output_enabled(oe),
        .power_cycling(pcyc));
    i2c_host host_u (.scl(scl), .sda_low(sda_low), .rd_data(rdd), .rd_tick(tick), .sda(sda));
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    task automatic wclk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wclk
    task automatic wb(input byte_t v, input logic e);
        logic a;
        host_u.wr(v, a);
        check(a, e);
    endtask : wb
    task automatic wcmd(input byte_t c, input byte_t d, input logic hd);
        host_u.start();
        wb(8'h20, 1'b1);
        wb(c, 1'b1);
        if (hd)
            wb(d, 1'b1);
        host_u.stop();
        wclk(20);
    endtask : wcmd
    task automatic rd(input byte_t c, input int n, input logic [39:0] e);
        byte_t v;
        host_u.start();
        wb(8'h20, 1'b1);
        wb(c, 1'b1);
        host_u.start();
        wb(8'h21, 1'b1);
        for (int k = n - 1; k >= 0; k--)
        begin
            expq.push_back(e[8*k +: 8]);
            host_u.rd(k != 0, v);
        end
        host_u.stop();
    endtask : rd
    // ----
    // result watchers
    // ----
    always @(tick)
        if (expq.size() > 0)
            check(rdd, expq.pop_front());
    always @(negedge clock)
        if (conv === 1'b1)
            convs++;
    initial
    begin
        #400000;
        miscompares++;
        summarize();
    end
    // ----
    // scenarios
    // ----
    initial
    begin
        {uv, ov, perm, oc, fet, pgi, ot, warn, rst_n} = {3'b101, 2'b00, 1'b1, 9'h0};
        wclk(12);
        rst_n = 1'b1;
        warn = 7'($urandom(32'h4c2a));
        sb = 8'h40 | {5'h0, warn[4], 1'b0, |{warn[6:5], warn[3:0]}};
        wclk(20);
        check(gate, 1'b1);
        check(pg, 1'b1);
        rd(8'h19, 1, 40'hb0);
        rd(8'h99, 5, {8'h04, "XYZC"});
        rd(8'h55, 1, 40'hff);
        check(gate, 1'b1);
        check(a1, |warn);
        // own segment then a foreign one; nothing acts before the stop
        host_u.start();
        wb(8'h20, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h00, 1'b1);
        host_u.start();
        wb(8'h22, 1'b0);
        wclk(20);
        check(gate, 1'b1);
        host_u.stop();
        wclk(20);
        check(gate, 1'b0);
        rd(8'h78, 1, {32'h0, sb});
        rd(8'h79, 2, {24'h0, sb, |warn[6:5], warn[0], |warn[3:1], 5'h08});
        wcmd(8'h01, 8'h80 | 8'($urandom), 1'b1);
        check(gate, 1'b1);
        {oc, fet, ot} = 3'b111;
        wclk(20);
        {oc, fet, ot} = 3'b000;
        wclk(20);
        check({fault_n, gate}, 2'b00);
        check(a2, 1'b1);
        wcmd(8'h01, 8'h00, 1'b1);
        wcmd(8'h01, 8'h80, 1'b1);
        check({fault_n, gate}, 2'b11);
        check({a2, pg}, 2'b01);
        {uv, ov, perm} = 3'b010;
        wcmd(8'h01, 8'h80, 1'b1);
        check(gate, 1'b0);
        {uv, ov, perm} = 3'b101;
        wcmd(8'h03, 8'h00, 1'b0);
        check(fault_n, 1'b1);
        wcmd(8'hf3, 8'h00, 1'b0);
        check(8'(convs), 8'h01);
        wcmd(8'hd9, 8'h00, 1'b0);
        check({pcyc, gate}, 2'b10);
        wclk(400);
        check({pcyc, gate}, 2'b01);
        // bus stuck low drops pending off command
        host_u.start();
        wb(8'h20, 1'b1);
        wb(8'h01, 1'b1);
        wb(8'h00, 1'b1);
        wclk(3000);
        host_u.stop();
        wclk(20);
        check(gate, 1'b1);
        summarize();
    end
endmodule : testbench
`default_nettype wire
